// ---- rtl/cpurf_core_regs.v ----
/*
 architectural register set of the core: sixteen general registers, status word,
 peripheral base, exception table base, mac halves, return address, program counter.
 assumes the execution unit drives the ports synchronously to clk_sys_in and that
 reset load of sp/pc comes over the vector load port after reset release.
*/
// Implementation choices: the strobed register port and the placing of the registers.
// How it works
// - sixteen 32-bit general registers, numbered 0 to 15, any use
// - register 0 also serves as index register for indexed addressing
// - dedicated read and write path to register 0 for implicit operands
// - register 15 is the stack pointer for exception save/restore
// - three 32-bit control registers: status, peripheral base, table base
// - peripheral base supplies base address for peripheral-access addressing
// - table base supplies exception and interrupt vector area base
// - four 32-bit system registers beside general and control registers
// - system registers: mac high, mac low, return address, program counter
// - reset clears table base, sets four mask bits, clears reserved bits
// - reset loads stack pointer and program counter from vector table
`timescale 1ns/1ps
`include "cpurf_regs.vh"
module cpurf_core_regs #(
   parameter WIDTH = 32
) (
   // clock and reset
   input wire clk_sys_in,
   input wire rst_n_in,
   // general register read ports
   input wire [3:0] rd_a_sel_in,
   input wire [3:0] rd_b_sel_in,
   // general register write port
   input wire gp_wr_in,
   input wire [3:0] gp_wr_sel_in,
   input wire [WIDTH-1:0] gp_wr_data_in,
   // implicit register 0 write port
   input wire idx_wr_in,
   input wire [WIDTH-1:0] idx_wr_data_in,
   // control/system register port
   input wire cs_wr_in,
   input wire [2:0] cs_wr_sel_in,
   input wire [WIDTH-1:0] cs_wr_data_in,
   input wire [2:0] cs_rd_sel_in,
   // reset vector load
   input wire vec_ld_in,
   input wire [WIDTH-1:0] vec_pc_in,
   input wire [WIDTH-1:0] vec_sp_in,
   // read data
   output reg [WIDTH-1:0] rd_a_data_out,
   output reg [WIDTH-1:0] rd_b_data_out,
   output reg [WIDTH-1:0] index_register_zero_out,
   output reg [WIDTH-1:0] stack_pointer_register_out,
   output reg [WIDTH-1:0] cs_rd_data_out,
   output reg [WIDTH-1:0] peripheral_base_pointer_out,
   output reg [WIDTH-1:0] exception_table_base_out,
   output reg [WIDTH-1:0] processing_status_word_out,
   output reg [3:0] interrupt_mask_bits_out,
   output reg [WIDTH-1:0] program_counter_out,
   output reg vec_pending_out
);
   reg [WIDTH-1:0] general_register_set_ff [0:15];
   reg [WIDTH-1:0] mac_result_high_ff;
   reg [WIDTH-1:0] mac_result_low_ff;
   reg [WIDTH-1:0] return_address_register_ff;
   reg [WIDTH-1:0] program_counter_ff;
   reg vec_pending_ff;
   wire [WIDTH-1:0] psw_q;
   wire [WIDTH-1:0] pbase_q;
   wire [WIDTH-1:0] vbase_q;
   reg [WIDTH-1:0] nxt_psw;
   integer i;

   // effective general writes: idx port loses to named port on same register
   wire idx_eff = idx_wr_in && !(gp_wr_in && gp_wr_sel_in == `CPURF_IDX_REG);
   wire cs_psw_wr = cs_wr_in && cs_wr_sel_in == `CPURF_SEL_STATUS;
   wire cs_pb_wr = cs_wr_in && cs_wr_sel_in == `CPURF_SEL_PBASE;
   wire cs_vb_wr = cs_wr_in && cs_wr_sel_in == `CPURF_SEL_VBASE;

   // reserved bits forced to zero on every write
   always @* begin
      nxt_psw = cs_wr_data_in & ~`CPURF_SR_RSV_MASK;
   end

   // status word, reset sets mask bits
   cpurf_word_reg #(.WIDTH(WIDTH), .RST_VAL(`CPURF_SR_RST)) u_psw (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .wr_en_in(cs_psw_wr),
      .wr_data_in(nxt_psw),
      .q_out(psw_q)
   );
   // peripheral base pointer, undefined at reset so zeroed
   cpurf_word_reg #(.WIDTH(WIDTH), .RST_VAL(`CPURF_ZERO32)) u_pbase (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .wr_en_in(cs_pb_wr),
      .wr_data_in(cs_wr_data_in),
      .q_out(pbase_q)
   );
   // exception table base cleared at reset
   cpurf_word_reg #(.WIDTH(WIDTH), .RST_VAL(`CPURF_VBASE_RST)) u_vbase (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .wr_en_in(cs_vb_wr),
      .wr_data_in(cs_wr_data_in),
      .q_out(vbase_q)
   );

   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (i = 0; i < 16; i = i + 1) begin
            general_register_set_ff[i] <= `CPURF_ZERO32;
         end
      end else begin
         if (gp_wr_in) begin
            general_register_set_ff[gp_wr_sel_in] <= gp_wr_data_in;
         end
         if (idx_eff) begin
            general_register_set_ff[`CPURF_IDX_REG] <= idx_wr_data_in;
         end
         // vector load wins over instruction writes to the stack pointer
         if (vec_ld_in && vec_pending_ff) begin
            general_register_set_ff[`CPURF_SP_REG] <= vec_sp_in;
         end
      end
   end

   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mac_result_high_ff <= `CPURF_ZERO32;
         mac_result_low_ff <= `CPURF_ZERO32;
         return_address_register_ff <= `CPURF_ZERO32;
         program_counter_ff <= `CPURF_ZERO32;
         vec_pending_ff <= 1'b1;
      end else begin
         if (cs_wr_in && cs_wr_sel_in == `CPURF_SEL_MAC_RESULT_HIGH) begin
            mac_result_high_ff <= cs_wr_data_in;
         end
         if (cs_wr_in && cs_wr_sel_in == `CPURF_SEL_MAC_RESULT_LOW) begin
            mac_result_low_ff <= cs_wr_data_in;
         end
         if (cs_wr_in && cs_wr_sel_in == `CPURF_SEL_RET) begin
            return_address_register_ff <= cs_wr_data_in;
         end
         // one-shot reset vector load of pc
         if (vec_ld_in && vec_pending_ff) begin
            program_counter_ff <= vec_pc_in;
            vec_pending_ff <= 1'b0;
         end else if (cs_wr_in && cs_wr_sel_in == `CPURF_SEL_PC) begin
            program_counter_ff <= cs_wr_data_in;
         end
      end
   end

   // forwarding: value the register holds after this edge
   function [WIDTH-1:0] gp_next;
      input [3:0] sel;
      begin
         gp_next = general_register_set_ff[sel];
         if (gp_wr_in && gp_wr_sel_in == sel) begin
            gp_next = gp_wr_data_in;
         end
         if (idx_eff && sel == `CPURF_IDX_REG) begin
            gp_next = idx_wr_data_in;
         end
         if (vec_ld_in && vec_pending_ff && sel == `CPURF_SP_REG) begin
            gp_next = vec_sp_in;
         end
      end
   endfunction

   reg [WIDTH-1:0] nxt_cs_rd;
   reg [WIDTH-1:0] nxt_pc;
   reg [WIDTH-1:0] nxt_psw_q;
   reg [WIDTH-1:0] nxt_pb_q;
   reg [WIDTH-1:0] nxt_vb_q;
   always @* begin
      nxt_psw_q = cs_psw_wr ? nxt_psw : psw_q;
      nxt_pb_q = cs_pb_wr ? cs_wr_data_in : pbase_q;
      nxt_vb_q = cs_vb_wr ? cs_wr_data_in : vbase_q;
      nxt_pc = program_counter_ff;
      if (vec_ld_in && vec_pending_ff) begin
         nxt_pc = vec_pc_in;
      end else if (cs_wr_in && cs_wr_sel_in == `CPURF_SEL_PC) begin
         nxt_pc = cs_wr_data_in;
      end
      case (cs_rd_sel_in)
         `CPURF_SEL_STATUS: nxt_cs_rd = nxt_psw_q;
         `CPURF_SEL_PBASE: nxt_cs_rd = nxt_pb_q;
         `CPURF_SEL_VBASE: nxt_cs_rd = nxt_vb_q;
         `CPURF_SEL_MAC_RESULT_HIGH: nxt_cs_rd = (cs_wr_in && cs_wr_sel_in == `CPURF_SEL_MAC_RESULT_HIGH) ?
            cs_wr_data_in : mac_result_high_ff;
         `CPURF_SEL_MAC_RESULT_LOW: nxt_cs_rd = (cs_wr_in && cs_wr_sel_in == `CPURF_SEL_MAC_RESULT_LOW) ?
            cs_wr_data_in : mac_result_low_ff;
         `CPURF_SEL_RET: nxt_cs_rd = (cs_wr_in && cs_wr_sel_in == `CPURF_SEL_RET) ?
            cs_wr_data_in : return_address_register_ff;
         `CPURF_SEL_PC: nxt_cs_rd = nxt_pc;
         default: nxt_cs_rd = `CPURF_ZERO32;
      endcase
   end

   // registered outputs, one cycle after selection, forwarded
   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_a_data_out <= `CPURF_ZERO32;
         rd_b_data_out <= `CPURF_ZERO32;
         index_register_zero_out <= `CPURF_ZERO32;
         stack_pointer_register_out <= `CPURF_ZERO32;
         cs_rd_data_out <= `CPURF_ZERO32;
         peripheral_base_pointer_out <= `CPURF_ZERO32;
         exception_table_base_out <= `CPURF_VBASE_RST;
         processing_status_word_out <= `CPURF_SR_RST;
         interrupt_mask_bits_out <= `CPURF_SR_MASK_RST;
         program_counter_out <= `CPURF_ZERO32;
         vec_pending_out <= 1'b1;
      end else begin
         rd_a_data_out <= gp_next(rd_a_sel_in);
         rd_b_data_out <= gp_next(rd_b_sel_in);
         index_register_zero_out <= gp_next(`CPURF_IDX_REG);
         // stack pointer view for exception save
         stack_pointer_register_out <= gp_next(`CPURF_SP_REG);
         cs_rd_data_out <= nxt_cs_rd;
         peripheral_base_pointer_out <= nxt_pb_q;
         exception_table_base_out <= nxt_vb_q;
         processing_status_word_out <= nxt_psw_q;
         interrupt_mask_bits_out <= nxt_psw_q[`CPURF_SR_MASK_HI:`CPURF_SR_MASK_LO];
         program_counter_out <= nxt_pc;
         vec_pending_out <= vec_pending_ff && !vec_ld_in;
      end
   end
endmodule // cpurf_core_regs

// ---- rtl/cpurf_regs.vh ----
/*
 core register set constants: register select codes, reset values,
 status word field positions. assumes includer defines nothing of the same name.
*/
`ifndef CPURF_REGS_VH
`define CPURF_REGS_VH

// register select codes for the control/system port
`define CPURF_SEL_STATUS 3'h0
`define CPURF_SEL_PBASE 3'h1
`define CPURF_SEL_VBASE 3'h2
`define CPURF_SEL_MAC_RESULT_HIGH 3'h3
`define CPURF_SEL_MAC_RESULT_LOW 3'h4
`define CPURF_SEL_RET 3'h5
`define CPURF_SEL_PC 3'h6

// general register numbers with fixed roles
`define CPURF_IDX_REG 4'h0
`define CPURF_SP_REG 4'hF

// status word layout
`define CPURF_SR_MASK_LO 4
`define CPURF_SR_MASK_HI 7
`define CPURF_SR_MASK_RST 4'hF
// bits 0,1 and 4 to 9 are live; everything else reads and writes as zero
`define CPURF_SR_RSV_MASK 32'hFFFFFC0C
`define CPURF_SR_RST 32'h000000F0

`define CPURF_VBASE_RST 32'h00000000
`define CPURF_ZERO32 32'h00000000

// vector table entry offsets for the reset fetch
`define CPURF_VEC_PC_OFS 32'h00000000
`define CPURF_VEC_SP_OFS 32'h00000004

`endif

// ---- rtl/cpurf_word_reg.v ----
/*
 one 32-bit word register with write enable.
 assumes a single synchronous clock and asynchronous active-low reset.
*/
`timescale 1ns/1ps
module cpurf_word_reg #(
   parameter WIDTH = 32,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   // clock and reset
   input wire clk_sys_in,
   input wire rst_n_in,
   // write side
   input wire wr_en_in,
   input wire [WIDTH-1:0] wr_data_in,
   // stored value
   output reg [WIDTH-1:0] q_out
);
   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q_out <= RST_VAL;
      end else if (wr_en_in) begin
         q_out <= wr_data_in;
      end
   end
endmodule // cpurf_word_reg

// ---- tb/cpurf_regs_properties.sv ----
/*
 checker for the core register set: write paths, reset vector load, status mask.
 assumes it is bound to cpurf_core_regs with one clock and async active-low reset.
*/
`timescale 1ns/1ps
`include "cpurf_regs.vh"
module cpurf_regs_chk (
   // clock and reset
   input wire clk_sys_in,
   input wire rst_n_in,
   // write side
   input wire [3:0] rd_a_sel_in,
   input wire gp_wr_in,
   input wire [3:0] gp_wr_sel_in,
   input wire [31:0] gp_wr_data_in,
   input wire idx_wr_in,
   input wire [31:0] idx_wr_data_in,
   input wire cs_wr_in,
   input wire [2:0] cs_wr_sel_in,
   input wire [31:0] cs_wr_data_in,
   input wire vec_ld_in,
   input wire [31:0] vec_pc_in,
   input wire [31:0] vec_sp_in,
   // watched outputs
   input wire [31:0] rd_a_data_out,
   input wire [31:0] index_register_zero_out,
   input wire [31:0] stack_pointer_register_out,
   input wire [31:0] peripheral_base_pointer_out,
   input wire [31:0] exception_table_base_out,
   input wire [31:0] processing_status_word_out,
   input wire [3:0] interrupt_mask_bits_out,
   input wire [31:0] program_counter_out,
   input wire vec_pending_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   // vector load wins over general writes to the stack pointer, so those cycles are left out
   mask_copy_a: assert property (
      interrupt_mask_bits_out ==
      processing_status_word_out[`CPURF_SR_MASK_HI:`CPURF_SR_MASK_LO])
      else $error("mask bits differ from status word");
   rsv_zero_a: assert property (
      (processing_status_word_out & `CPURF_SR_RSV_MASK) == 32'h00000000)
      else $error("status reserved bits not zero");
   gp_forward_a: assert property (
      gp_wr_in && gp_wr_sel_in == rd_a_sel_in && !(vec_pending_out && vec_ld_in)
      |=> rd_a_data_out == $past(gp_wr_data_in))
      else $error("read port A missed same-cycle write");
   idx_path_a: assert property (
      idx_wr_in && !(gp_wr_in && gp_wr_sel_in == 4'h0)
      |=> index_register_zero_out == $past(idx_wr_data_in))
      else $error("implicit register 0 write lost");
   sp_write_a: assert property (
      gp_wr_in && gp_wr_sel_in == 4'hF && !(vec_pending_out && vec_ld_in)
      |=> stack_pointer_register_out == $past(gp_wr_data_in))
      else $error("stack pointer write lost");
   vec_load_a: assert property (
      vec_pending_out && vec_ld_in |=> !vec_pending_out
      && program_counter_out == $past(vec_pc_in)
      && stack_pointer_register_out == $past(vec_sp_in))
      else $error("reset vector load wrong");
   pend_stays_a: assert property (
      !vec_pending_out |=> !vec_pending_out[*3])
      else $error("vector load pending came back");
   pbase_write_a: assert property (
      cs_wr_in && cs_wr_sel_in == `CPURF_SEL_PBASE
      |=> peripheral_base_pointer_out == $past(cs_wr_data_in))
      else $error("peripheral base write lost");
   vbase_write_a: assert property (
      cs_wr_in && cs_wr_sel_in == `CPURF_SEL_VBASE
      |=> exception_table_base_out == $past(cs_wr_data_in))
      else $error("table base write lost");
endmodule // cpurf_regs_chk

bind cpurf_core_regs cpurf_regs_chk u_chk (.*);

// ---- tb/testbench.sv ----
/*
 self-checking bench for the core register set.
 assumes the checker file is compiled alongside; drives all ports itself.
*/
`timescale 1ns/1ps
module testbench;
   logic clk_sys_in, rst_n_in, gp_wr_in, idx_wr_in, cs_wr_in, vec_ld_in, vec_pending_out;
   logic [3:0] rd_a_sel_in, rd_b_sel_in, gp_wr_sel_in, interrupt_mask_bits_out;
   logic [2:0] cs_wr_sel_in, cs_rd_sel_in;
   logic [31:0] gp_wr_data_in, idx_wr_data_in, cs_wr_data_in, vec_pc_in, vec_sp_in;
   logic [31:0] rd_a_data_out, rd_b_data_out, index_register_zero_out, cs_rd_data_out;
   logic [31:0] stack_pointer_register_out, peripheral_base_pointer_out;
   logic [31:0] exception_table_base_out, processing_status_word_out, program_counter_out;
   int failures, check_count;
   cpurf_core_regs DUT (.*);
   always #2.5 clk_sys_in = ~clk_sys_in;
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // write and read back on port A in the same cycle
   task wr_gp(input logic [3:0] s, input logic [31:0] d);
      @(posedge clk_sys_in) gp_wr_in <= 1'b1;
      gp_wr_sel_in <= s; gp_wr_data_in <= d; rd_a_sel_in <= s;
      @(posedge clk_sys_in) gp_wr_in <= 1'b0;
      #1 chk(rd_a_data_out, d);
   endtask
   task rd_gp(input logic [3:0] s, input logic [31:0] exp);
      @(posedge clk_sys_in) rd_b_sel_in <= s;
      @(posedge clk_sys_in) #1 chk(rd_b_data_out, exp);
   endtask
   task wr_cs(input logic [2:0] s, input logic [31:0] d);
      @(posedge clk_sys_in) cs_wr_in <= 1'b1;
      cs_wr_sel_in <= s; cs_wr_data_in <= d; cs_rd_sel_in <= s;
      @(posedge clk_sys_in) cs_wr_in <= 1'b0;
      #1 chk(cs_rd_data_out, d);
   endtask
   initial begin
      #20000 failures++;
      $display("[ERR] %0t watchdog expired", $time);
      conclude;
   end
   initial begin
      {clk_sys_in, rst_n_in, gp_wr_in, idx_wr_in, cs_wr_in, vec_ld_in} = '0;
      {rd_a_sel_in, rd_b_sel_in, gp_wr_sel_in, cs_wr_sel_in, cs_rd_sel_in} = '0;
      {gp_wr_data_in, idx_wr_data_in, cs_wr_data_in, vec_pc_in, vec_sp_in} = '0;
      repeat (3) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      #1 chk(processing_status_word_out, 32'h000000F0);
      chk({28'h0, interrupt_mask_bits_out}, 32'h0000000F);
      chk(exception_table_base_out, 32'h00000000);
      chk({31'h0, vec_pending_out}, 32'h00000001);
      $display("test reset values done");
      // vector load beats a write to the stack pointer in the same cycle
      @(posedge clk_sys_in) vec_ld_in <= 1'b1;
      vec_pc_in <= 32'h00001000; vec_sp_in <= 32'h0000FFF0;
      gp_wr_in <= 1'b1; gp_wr_sel_in <= 4'hF; gp_wr_data_in <= 32'h12345678;
      @(posedge clk_sys_in) vec_ld_in <= 1'b0;
      gp_wr_in <= 1'b0; vec_pc_in <= 32'h0000DEAD;
      #1 chk(program_counter_out, 32'h00001000);
      chk(stack_pointer_register_out, 32'h0000FFF0);
      chk({31'h0, vec_pending_out}, 32'h00000000);
      // a second load must be ignored until the next reset
      @(posedge clk_sys_in) vec_ld_in <= 1'b1;
      @(posedge clk_sys_in) vec_ld_in <= 1'b0;
      #1 chk(program_counter_out, 32'h00001000);
      $display("test vector load done");
      for (int i = 0; i < 16; i++) wr_gp(i[3:0], 32'hC0DE0000 + i);
      for (int i = 0; i < 16; i++) rd_gp(i[3:0], 32'hC0DE0000 + i);
      chk(stack_pointer_register_out, 32'hC0DE000F);
      chk(index_register_zero_out, 32'hC0DE0000);
      $display("test general registers done");
      @(posedge clk_sys_in) idx_wr_in <= 1'b1;
      idx_wr_data_in <= 32'h0000BEEF;
      @(posedge clk_sys_in) idx_wr_in <= 1'b0;
      #1 chk(index_register_zero_out, 32'h0000BEEF);
      // general port wins over the implicit port on register 0
      @(posedge clk_sys_in) idx_wr_in <= 1'b1;
      gp_wr_in <= 1'b1; gp_wr_sel_in <= 4'h0; gp_wr_data_in <= 32'h00000777;
      @(posedge clk_sys_in) idx_wr_in <= 1'b0;
      gp_wr_in <= 1'b0;
      #1 chk(index_register_zero_out, 32'h00000777);
      $display("test implicit register 0 done");
      for (int s = 0; s < 7; s++) wr_cs(s[2:0], s == 0 ? 32'h50 : 32'h80000100 + s);
      chk({28'h0, interrupt_mask_bits_out}, 32'h00000005);
      chk(peripheral_base_pointer_out, 32'h80000101);
      chk(exception_table_base_out, 32'h80000102);
      chk(program_counter_out, 32'h80000106);
      // all ones into the status word: only the live bits may stick
      @(posedge clk_sys_in) cs_wr_in <= 1'b1;
      cs_wr_sel_in <= 3'h0; cs_wr_data_in <= 32'hFFFFFFFF;
      @(posedge clk_sys_in) cs_wr_in <= 1'b0;
      #1 chk(processing_status_word_out, 32'h000003F3);
      chk({28'h0, interrupt_mask_bits_out}, 32'h0000000F);
      @(posedge clk_sys_in) cs_rd_sel_in <= 3'h7;
      @(posedge clk_sys_in) #1 chk(cs_rd_data_out, 32'h00000000);
      $display("test control and system registers done");
      conclude;
   end
endmodule // testbench
